// ### mcu_instruction_exec_timing_tb_top.sv
/*
 Self-checking bench for the sequencing core with memory model.
 Assumes the default parameters and the hand-over word encoding.
*/
`timescale 1ns/10ps
`default_nettype none

module mcu_instruction_exec_timing_tb_top;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wake_i = 1'b0;
	logic [10:0] prog_addr;
	logic [15:0] prog_data;
	logic [7:0] dmem_addr, dmem_rdata, dmem_wdata, acc, peek, alias_w;
	logic dmem_we, power_down, wdt_clear, intr_exit, done, carry, zero;
	logic clr = 1'b0;
	logic ld = 1'b0;
	logic ld_prog = 1'b0;
	logic [10:0] ld_addr = 11'h000;
	logic [15:0] ld_val = 16'h0000;
	logic [7:0] peek_addr = 8'h00;
	int miscompares = 0;
	int comparisons = 0;
	int cyc, ref_first, wdt_n, intr_n, k;
	int dt[$];
	logic [15:0] pq[$], dq[$], eq[$];

	miet_core i_miet_core (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.prog_addr_o(prog_addr), .prog_data_i(prog_data),
		.dmem_addr_o(dmem_addr), .dmem_rdata_i(dmem_rdata),
		.dmem_we_o(dmem_we), .dmem_wdata_o(dmem_wdata),
		.wake_i(wake_i), .power_down_o(power_down),
		.wdt_clear_o(wdt_clear), .intr_exit_o(intr_exit),
		.instr_done_o(done), .acc_o(acc), .carry_o(carry),
		.zero_o(zero));

	miet_mem_model i_miet_mem_model (.ref_clk_i(ref_clk_i),
		.clr_i(clr), .ld_i(ld), .ld_prog_i(ld_prog),
		.ld_addr_i(ld_addr), .ld_val_i(ld_val),
		.prog_addr_i(prog_addr), .prog_data_o(prog_data),
		.dmem_addr_i(dmem_addr), .dmem_rdata_o(dmem_rdata),
		.dmem_we_i(dmem_we), .dmem_wdata_i(dmem_wdata),
		.peek_addr_i(peek_addr), .peek_o(peek),
		.alias_writes_o(alias_w));

	initial
	begin
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	// Completion times, counted in clocks since reset ended
	always @(posedge ref_clk_i)
	begin
		cyc <= rst_i ? 0 : cyc + 1;
		wdt_n <= rst_i ? 0 : wdt_n + int'(wdt_clear === 1'b1);
		intr_n <= rst_i ? 0 : intr_n + int'(intr_exit === 1'b1);
		if (!rst_i && done === 1'b1)
			dt.push_back(cyc);
	end

	task automatic complete_run;
		$display("comparisons %0d miscompares %0d", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] got,
		input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic load(input logic sel, input int a, input logic [15:0] v);
		ld <= 1'b1;
		ld_prog <= sel;
		ld_addr <= a[10:0];
		ld_val <= v;
		@(posedge ref_clk_i);
	endtask

	// Core held in reset while both memories are rebuilt
	task automatic prep;
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		clr <= 1'b1;
		@(posedge ref_clk_i);
		clr <= 1'b0;
		foreach (pq[i])
			load(1'b1, i, pq[i]);
		foreach (dq[i])
			load(1'b0, int'(dq[i][15:8]), {8'h00, dq[i][7:0]});
	endtask

	task automatic go;
		ld <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		dt.delete();
	endtask

	task automatic wait_done(input int n);
		repeat (600)
			if (dt.size() < n)
			begin
				@(posedge ref_clk_i);
				#1;
			end
		if (dt.size() < n)
		begin
			miscompares++;
			$display("[FAIL] completions expected %0d seen %0d", n, dt.size());
			complete_run();
		end
	endtask

	task automatic span(input int i, input int c);
		check("instruction span", 16'(dt[i + 1] - dt[i - 1]), 16'(4 * (1 + c)));
	endtask

	// Compares data memory against address and value pairs in eq
	task automatic mem_check;
		foreach (eq[i])
		begin
			peek_addr <= eq[i][15:8];
			@(posedge ref_clk_i);
			#1;
			check("data memory", {8'h00, peek}, {8'h00, eq[i][7:0]});
		end
	endtask

	task automatic scen_flow;
		pq = '{16'h305A, 16'h2020, 16'hB010, 16'h1021, 16'hA008, 16'h30FF,
			16'h30FF, 16'h30FF, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
			16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h3011, 16'h0100};
		dq = '{16'h2133};
		prep();
		go();
		wait_done(8);
		ref_first = dt[0];
		check("acc", {8'h00, acc}, 16'h0033);
		span(1, 1);
		span(2, 2);
		span(4, 2);
		span(6, 2);
		eq = '{16'h205A};
		mem_check();
	endtask

	task automatic scen_alu;
		pq = '{16'h3020, 16'h4030, 16'h5D40, 16'h6211, 16'h5D41, 16'h620F,
			16'h5D42, 16'h5843, 16'h4944, 16'h2045, 16'h5A46, 16'h5B49,
			16'h5C47, 16'h5D48, 16'h464A};
		dq = '{16'h30F0, 16'h43FF, 16'h4681, 16'h4981, 16'h4701, 16'h4AFF};
		prep();
		go();
		wait_done(15);
		check("first completion", 16'(dt[0]), 16'(ref_first));
		check("acc", {8'h00, acc}, 16'h0000);
		check("zero", {15'h0000, zero}, 16'h0001);
		check("carry", {15'h0000, carry}, 16'h0000);
		span(7, 1);
		eq = '{16'h4001, 16'h4100, 16'h4201, 16'h4300, 16'h4400, 16'h45FF,
			16'h46C0, 16'h4903, 16'h4700, 16'h4801};
		mem_check();
	endtask

	task automatic scen_skip_table;
		pq = '{16'h0000, 16'h9051, 16'h9050, 16'h30EE, 16'h8F51, 16'h30EE,
			16'h7B52, 16'h7751, 16'h5753, 16'h300E, 16'h2006, 16'h30EE,
			16'h30EE, 16'h30EE, 16'h3070, 16'h2007, 16'h0554, 16'h1008,
			16'h9255, 16'h30EE, 16'h0000};
		dq = '{16'h5180, 16'h5201, 16'h530F, 16'h55FF};
		prep();
		load(1'b1, 'h70, 16'hBEEF);
		go();
		wait_done(15);
		check("acc", {8'h00, acc}, 16'h00BE);
		span(1, 1);
		span(8, 2);
		span(11, 2);
		span(13, 2);
		check("alias writes", {8'h00, alias_w}, 16'h0000);
		eq = '{16'h5209, 16'h5100, 16'h53F0, 16'h54EF, 16'h5500, 16'h0600};
		mem_check();
	endtask

	// Carry-in forms, or, and, swap, clear and the remaining skips
	task automatic scen_more;
		pq = '{16'h30F0, 16'h6020, 16'h4160, 16'h4361, 16'h4563, 16'h4460,
			16'h5E63, 16'h5F62, 16'h9162, 16'h30EE, 16'h9361, 16'h30EE,
			16'h9560, 16'h9463, 16'h0000};
		dq = '{16'h600F, 16'h6101, 16'h6202, 16'h63F0};
		prep();
		go();
		wait_done(13);
		check("acc", {8'h00, acc}, 16'h0010);
		check("carry", {15'h0000, carry}, 16'h0001);
		check("zero", {15'h0000, zero}, 16'h0000);
		span(8, 2);
		span(11, 1);
		eq = '{16'h600F, 16'h6100, 16'h6200, 16'h630F};
		mem_check();
	endtask

	task automatic scen_halt;
		pq = '{16'h0400, 16'hB005, 16'h0300, 16'hB006, 16'h0000, 16'h0200,
			16'hC077};
		dq = '{};
		prep();
		go();
		for (k = 0; k < 200 && power_down !== 1'b1; k++)
		begin
			@(posedge ref_clk_i);
			#1;
		end
		// Let the halt's own completion land before counting
		@(posedge ref_clk_i);
		#1;
		k = dt.size();
		repeat (20) @(posedge ref_clk_i);
		#1;
		check("power down", {15'h0000, power_down}, 16'h0001);
		check("halted completions", 16'(dt.size()), 16'(k));
		check("watchdog clears", 16'(wdt_n), 16'h0001);
		check("interrupt exits", 16'(intr_n), 16'h0001);
		@(posedge ref_clk_i);
		wake_i <= 1'b1;
		wait_done(k + 3);
		check("power down", {15'h0000, power_down}, 16'h0000);
		check("acc", {8'h00, acc}, 16'h0077);
		wake_i <= 1'b0;
	endtask

	initial
	begin
		repeat (6) @(posedge ref_clk_i);
		scen_flow();
		scen_alu();
		scen_skip_table();
		scen_more();
		scen_halt();
		complete_run();
	end
endmodule

`default_nettype wire

// ### miet_alu.sv
/*
 Eight-bit arithmetic, logic, rotate and swap unit.
 Assumes carry in is the core carry flag; carry out after a
 subtract is set when no borrow occurred.
*/
`timescale 1ns/10ps
`default_nettype none

module miet_alu (
	// Operation
	input wire miet_pkg::miet_fn_type fn_i,
	// Operands
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic c_i,
	// Result
	output logic [7:0] res_o,
	output logic c_o,
	output logic upd_c_o,
	output logic upd_z_o
);
	import miet_pkg::*;

	logic [8:0] sum;
	logic [7:0] bx;
	logic ci;
	logic sub;

	assign sub = (fn_i == FN_SUB) || (fn_i == FN_SBC);

	always_comb
	begin
		bx = sub ? ~b_i : b_i;
		ci = (fn_i == FN_ADD) ? 1'h0 : (fn_i == FN_SUB) ? 1'h1 : c_i;
		sum = {1'h0, a_i} + {1'h0, bx} + {8'h00, ci};
		res_o = b_i;
		c_o = c_i;
		upd_c_o = 1'h0;
		upd_z_o = 1'h1;
		case (fn_i)
		// Ninth bit keeps carry or borrow
		FN_ADD, FN_ADC, FN_SUB, FN_SBC:
		begin
			res_o = sum[7:0];
			c_o = sum[8];
			upd_c_o = 1'h1;
		end
		FN_AND: res_o = a_i & b_i;
		FN_OR: res_o = a_i | b_i;
		FN_XOR: res_o = a_i ^ b_i;
		FN_INVERT: res_o = ~b_i;
		FN_INC: res_o = b_i + 8'h01;
		FN_DEC: res_o = b_i - 8'h01;
		FN_RIGHT_ROTATE:
		begin
			res_o = {b_i[0], b_i[7:1]};
			upd_z_o = 1'h0;
		end
		FN_LEFT_ROTATE:
		begin
			res_o = {b_i[6:0], b_i[7]};
			upd_z_o = 1'h0;
		end
		FN_RIGHT_ROTATE_VIA_CARRY:
		begin
			res_o = {c_i, b_i[7:1]};
			c_o = b_i[0];
			upd_c_o = 1'h1;
			upd_z_o = 1'h0;
		end
		FN_LEFT_ROTATE_VIA_CARRY:
		begin
			res_o = {b_i[6:0], c_i};
			c_o = b_i[7];
			upd_c_o = 1'h1;
			upd_z_o = 1'h0;
		end
		FN_SWAP:
		begin
			res_o = {b_i[3:0], b_i[7:4]};
			upd_z_o = 1'h0;
		end
		default:
		begin
			res_o = 8'h00;
			upd_z_o = 1'h0;
		end
		endcase
	end

endmodule
`default_nettype wire

// ### miet_cfg.svh
/*
 Constants for the instruction sequencing core: timing, widths,
 reset values and the data addresses that alias core registers.
 Assumes inclusion by the core and its helper modules.
*/
`ifndef MIET_CFG_SVH
`define MIET_CFG_SVH

`define MIET_PHASES 4
`define MIET_PHASE_W 2
`define MIET_PHASE_LAST 2'h3
`define MIET_PHASE_FETCH 2'h1
`define MIET_CLK_NS 40
`define MIET_IW 16
`define MIET_DW 8
`define MIET_PC_W 11
`define MIET_STACK_DEPTH 4
`define MIET_RESET_ACC 8'h00
`define MIET_ADDR_PCL 8'h06
`define MIET_ADDR_TPTR 8'h07
`define MIET_ADDR_THI 8'h08
`define MIET_OP_MSB 15
`define MIET_OP_LSB 12
`define MIET_MINOR_MSB 11
`define MIET_MINOR_LSB 8
`define MIET_SET_BIT 3

`endif

// ### miet_core.sv
/*
 Instruction sequencing core: fetch, decode, execute, one- and
 two-cycle timing, call stack, table reads and power-down.
 Assumes program and data memories with one-clock synchronous read
 and a wake level arriving from outside the clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "miet_cfg.svh"

// Behaviour
// - Plain instructions take one cycle; branch, call, exits, table take two.
// - An instruction cycle is four consecutive clocks.
// - Writing the low program counter byte jumps and costs one extra cycle.
// - A skip costs one cycle, or two when it skips.
// - Transfers: memory to acc, acc to memory, immediate to acc.
// - Add overflow past 255 and subtract borrow below zero are kept.
// - Increment and decrement step by one, into memory or acc.
// - Logical operations set the zero flag on a zero result.
// - Logical operations other than invert combine a value with the accumulator.
// - Rotates move one place; carry variants move the bit out to carry.
// - Call saves return point; exit resumes right after the call.
// - Unconditional branch loads the target and saves nothing.
// - Conditional skips test a byte or bit and may skip one.
// - Bit set and clear rewrite the byte, changing only that bit.
// - Table reads take program memory data into data memory.
// - One instruction powers down; another clears the watchdog.
module miet_core #(
	parameter int PC_W = `MIET_PC_W,
	parameter int STACK_DEPTH = `MIET_STACK_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Program memory
	output logic [PC_W-1:0] prog_addr_o,
	input wire logic [`MIET_IW-1:0] prog_data_i,
	// Data memory
	output logic [`MIET_DW-1:0] dmem_addr_o,
	input wire logic [`MIET_DW-1:0] dmem_rdata_i,
	output logic dmem_we_o,
	output logic [`MIET_DW-1:0] dmem_wdata_o,
	// Power and watchdog
	input wire logic wake_i,
	output logic power_down_o,
	output logic wdt_clear_o,
	output logic intr_exit_o,
	// Status
	output logic instr_done_o,
	output logic [`MIET_DW-1:0] acc_o,
	output logic carry_o,
	output logic zero_o
);
	import miet_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH);

	if (PC_W < 9 || PC_W > 12)
	begin : g_bad_pc
		$error("program counter width must be 9 to 12");
	end
	if (STACK_DEPTH < 2 || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0)
	begin : g_bad_stack
		$error("stack depth must be a power of two");
	end

	logic [1:0] phase;
	logic cyc_end;
	miet_state_type state, next_state;
	logic [PC_W-1:0] pc, next_pc, pc_inc, pc_two, target, top, tbl_addr;
	logic [`MIET_IW-1:0] instr, tword;
	miet_op_type op;
	miet_fn_type fn;
	logic [3:0] minor;
	logic [7:0] maddr, opnd, wr_val, mask, alu_b, alu_res, skv;
	logic [7:0] acc, next_acc, tptr, thi;
	logic c_flag, z_flag, next_c, next_z, alu_c, upd_c, upd_z;
	logic exec, wr, special, two, skip, push, pop;
	logic halt, wdt, iexit, go_table, tbl_done;
	logic [PC_W-1:0] stack [STACK_DEPTH];
	logic [SP_W-1:0] sp;
	logic wk1, wk2, wk3, wake;

	miet_phase u_phase (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.phase_o(phase),
		.last_o(cyc_end)
	);

	assign op = miet_op_type'(instr[`MIET_OP_MSB:`MIET_OP_LSB]);
	assign minor = instr[`MIET_MINOR_MSB:`MIET_MINOR_LSB];
	assign fn = miet_fn_type'(minor);
	assign maddr = instr[7:0];
	assign target = instr[PC_W-1:0];
	assign pc_inc = pc + 1'h1;
	assign pc_two = pc + 2'h2;
	assign top = stack[sp - 1'h1];
	assign tbl_addr = {pc[PC_W-1:8], tptr};
	assign mask = 8'h01 << minor[2:0];
	assign exec = (state == ST_RUN) && cyc_end;
	assign tbl_done = (state == ST_TABLE) && cyc_end;
	assign special = (maddr == `MIET_ADDR_PCL) ||
		(maddr == `MIET_ADDR_TPTR) || (maddr == `MIET_ADDR_THI);
	assign alu_b = (op == OP_ALU_IMM) ? maddr : opnd;
	assign acc_o = acc;
	assign carry_o = c_flag;
	assign zero_o = z_flag;

	miet_alu u_alu (
		.fn_i(fn),
		.a_i(acc),
		.b_i(alu_b),
		.c_i(c_flag),
		.res_o(alu_res),
		.c_o(alu_c),
		.upd_c_o(upd_c),
		.upd_z_o(upd_z)
	);

	// Core registers alias a few data addresses
	always_comb
	begin
		case (maddr)
		`MIET_ADDR_PCL: opnd = pc[7:0];
		`MIET_ADDR_TPTR: opnd = tptr;
		`MIET_ADDR_THI: opnd = thi;
		default: opnd = dmem_rdata_i;
		endcase
	end

	always_comb
	begin
		next_acc = acc;
		next_c = c_flag;
		next_z = z_flag;
		next_pc = pc_inc;
		wr = 1'h0;
		wr_val = opnd;
		two = 1'h0;
		skip = 1'h0;
		push = 1'h0;
		pop = 1'h0;
		halt = 1'h0;
		wdt = 1'h0;
		iexit = 1'h0;
		go_table = 1'h0;
		skv = opnd;
		case (op)
		OP_MISC:
		begin
			case (miet_misc_type'(minor))
			MS_SUBROUTINE_EXIT, MS_INTERRUPT_EXIT:
			begin
				pop = 1'h1;
				next_pc = top;
				two = 1'h1;
				iexit = (minor == MS_INTERRUPT_EXIT);
			end
			MS_HALT: halt = 1'h1;
			MS_WDT_CLEAR: wdt = 1'h1;
			MS_TABLE_READ: go_table = 1'h1;
			default: next_pc = pc_inc;
			endcase
		end
		OP_LOAD_MEM: next_acc = opnd;
		OP_STORE_MEM:
		begin
			wr = 1'h1;
			wr_val = acc;
		end
		OP_LOAD_IMM: next_acc = maddr;
		OP_ALU_ACC, OP_ALU_MEM, OP_ALU_IMM:
		begin
			next_c = upd_c ? alu_c : c_flag;
			next_z = upd_z ? (alu_res == 8'h00) : z_flag;
			wr = (op == OP_ALU_MEM);
			wr_val = alu_res;
			next_acc = (op == OP_ALU_MEM) ? acc : alu_res;
		end
		// Read, change one bit, write back
		OP_BIT:
		begin
			wr = 1'h1;
			wr_val = minor[`MIET_SET_BIT] ? (opnd | mask) : (opnd & ~mask);
		end
		OP_SKIP_BIT:
			skip = minor[`MIET_SET_BIT] ? |(opnd & mask) : ~|(opnd & mask);
		OP_SKIP:
		begin
			case (miet_skip_type'(minor))
			SK_INC, SK_INC_ACC: skv = opnd + 8'h01;
			SK_DEC, SK_DEC_ACC: skv = opnd - 8'h01;
			default: skv = opnd;
			endcase
			skip = (skv == 8'h00);
			wr = (minor == SK_INC) || (minor == SK_DEC);
			wr_val = skv;
			next_acc = (minor == SK_ZERO || wr) ? acc : skv;
		end
		OP_BRANCH:
		begin
			next_pc = target;
			two = 1'h1;
		end
		OP_CALL:
		begin
			push = 1'h1;
			next_pc = target;
			two = 1'h1;
		end
		OP_EXIT_IMM:
		begin
			pop = 1'h1;
			next_acc = maddr;
			next_pc = top;
			two = 1'h1;
		end
		default: next_pc = pc_inc;
		endcase
		// A taken skip passes one word
		if (skip)
		begin
			next_pc = pc_two;
			two = 1'h1;
		end
		// Low byte write is a jump
		if (wr && maddr == `MIET_ADDR_PCL)
		begin
			next_pc = {pc[PC_W-1:8], wr_val};
			two = 1'h1;
		end
		if (halt)
			next_state = ST_HALT;
		else if (go_table)
			next_state = ST_TABLE;
		else if (two)
			next_state = ST_DEAD;
		else
			next_state = ST_RUN;
	end

	// Three flops; level accepted when the last two agree
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			wk1 <= 1'h0;
			wk2 <= 1'h0;
			wk3 <= 1'h0;
			wake <= 1'h0;
		end
		else
		begin
			wk1 <= wake_i;
			wk2 <= wk1;
			wk3 <= wk2;
			wake <= (wk2 == wk3) ? wk3 : wake;
		end
	end

	// State moves only on cycle boundaries
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			state <= ST_RUN;
		else if (cyc_end)
		begin
			case (state)
			ST_RUN: state <= next_state;
			ST_HALT: state <= wake ? ST_RUN : ST_HALT;
			default: state <= ST_RUN;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			pc <= '0;
			prog_addr_o <= '0;
		end
		else if (exec)
		begin
			pc <= next_pc;
			prog_addr_o <= (next_state == ST_TABLE) ? tbl_addr : next_pc;
		end
		else if (tbl_done)
			prog_addr_o <= pc;
	end

	// Fetch late in phase one; memory needs a clock after the address
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			instr <= '0;
			tword <= '0;
			dmem_addr_o <= 8'h00;
		end
		else if (phase == `MIET_PHASE_FETCH && state == ST_RUN)
		begin
			instr <= prog_data_i;
			dmem_addr_o <= prog_data_i[7:0];
		end
		else if (phase == `MIET_PHASE_FETCH && state == ST_TABLE)
			tword <= prog_data_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			acc <= `MIET_RESET_ACC;
			c_flag <= 1'h0;
			z_flag <= 1'h0;
		end
		else if (exec)
		begin
			acc <= next_acc;
			c_flag <= next_c;
			z_flag <= next_z;
		end
	end

	// Return point is the word after the call
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			sp <= '0;
		else if (exec && push)
		begin
			stack[sp] <= pc_inc;
			sp <= sp + 1'h1;
		end
		else if (exec && pop)
			sp <= sp - 1'h1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			tptr <= 8'h00;
			thi <= 8'h00;
		end
		else if (exec && wr && maddr == `MIET_ADDR_TPTR)
			tptr <= wr_val;
		else if (exec && wr && maddr == `MIET_ADDR_THI)
			thi <= wr_val;
		else if (tbl_done)
			thi <= tword[15:8];
	end

	// Aliased addresses reach data memory only through a table write
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			dmem_we_o <= 1'h0;
			dmem_wdata_o <= 8'h00;
		end
		else
		begin
			dmem_we_o <= (exec && wr && !special) || tbl_done;
			if (exec && wr)
				dmem_wdata_o <= wr_val;
			else if (tbl_done)
				dmem_wdata_o <= tword[7:0];
		end
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
		begin
			wdt_clear_o <= 1'h0;
			intr_exit_o <= 1'h0;
			instr_done_o <= 1'h0;
			power_down_o <= 1'h0;
		end
		else
		begin
			wdt_clear_o <= exec && wdt;
			intr_exit_o <= exec && iexit;
			instr_done_o <= exec;
			if (exec && halt)
				power_down_o <= 1'h1;
			else if (state == ST_HALT && cyc_end && wake)
				power_down_o <= 1'h0;
		end
	end

	a_done_spacing: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		instr_done_o |=> !instr_done_o [*3])
		else $error("instruction cycles closer than four clocks");

	a_branch_two: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && (op == OP_BRANCH || op == OP_CALL) |=>
			(state == ST_DEAD) [*4] ##1 (state == ST_RUN))
		else $error("branch or call not two cycles");

	a_low_byte_jump: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && wr && maddr == `MIET_ADDR_PCL |=>
			pc[7:0] == $past(wr_val) && state == ST_DEAD)
		else $error("low byte write did not jump with extra cycle");

	a_skip_taken: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && skip |=> pc == $past(pc_two) && state == ST_DEAD)
		else $error("taken skip wrong target or timing");

	a_load_imm: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && op == OP_LOAD_IMM |=> acc == $past(maddr))
		else $error("immediate not loaded to accumulator");

	a_add_carry: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && op == OP_ALU_ACC && fn == FN_ADD |=>
			c_flag == (({1'h0, $past(acc)} + {1'h0, $past(opnd)}) > 9'h0FF))
		else $error("add carry not recorded");

	a_inc_one: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && (op == OP_ALU_ACC || op == OP_ALU_MEM) && fn == FN_INC |=>
			($past(op) == OP_ALU_ACC ? acc : dmem_wdata_o) ==
			8'($past(opnd) + 8'h01))
		else $error("increment did not add one");

	a_logic_zero: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && op == OP_ALU_ACC && (fn == FN_AND || fn == FN_XOR) |=>
			z_flag == (acc == 8'h00))
		else $error("zero flag wrong after logical op");

	a_rotate_carry: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && (op == OP_ALU_ACC || op == OP_ALU_MEM) &&
			fn == FN_RIGHT_ROTATE_VIA_CARRY |=>
			c_flag == $past(opnd[0]))
		else $error("rotate did not move bit to carry");

	a_call_saves: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && op == OP_CALL |=> stack[$past(sp)] == $past(pc_inc))
		else $error("call saved wrong return point");

	a_branch_plain: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && op == OP_BRANCH |=> sp == $past(sp) && pc == $past(target))
		else $error("branch touched stack or missed target");

	a_bit_rmw: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && op == OP_BIT && !special |=> dmem_we_o &&
			((dmem_wdata_o ^ $past(opnd)) & ~$past(mask)) == 8'h00)
		else $error("bit operation changed other bits");

	a_table_write: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		tbl_done |=> dmem_we_o && dmem_wdata_o == $past(tword[7:0]))
		else $error("table data not written to data memory");

	a_halt_enter: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		exec && halt |=> power_down_o && state == ST_HALT)
		else $error("halt did not power down");

endmodule
`default_nettype wire

// ### miet_mem_model.sv
/*
 Program and data memory model facing the sequencing core.
 Assumes one clock, a loader driven by the bench while the core is
 held in reset, and an 11-bit program address.
*/
`timescale 1ns/10ps
`default_nettype none

module miet_mem_model (
	// Clock
	input wire logic ref_clk_i,
	// Loader
	input wire logic clr_i,
	input wire logic ld_i,
	input wire logic ld_prog_i,
	input wire logic [10:0] ld_addr_i,
	input wire logic [15:0] ld_val_i,
	// Program side
	input wire logic [10:0] prog_addr_i,
	output logic [15:0] prog_data_o,
	// Data side
	input wire logic [7:0] dmem_addr_i,
	output logic [7:0] dmem_rdata_o,
	input wire logic dmem_we_i,
	input wire logic [7:0] dmem_wdata_i,
	// Inspection
	input wire logic [7:0] peek_addr_i,
	output logic [7:0] peek_o,
	output logic [7:0] alias_writes_o
);
	logic [15:0] prog [0:2047];
	logic [7:0] data [0:255];

	assign peek_o = data[peek_addr_i];

	// One clock read latency, no faster than the real arrays
	always_ff @(posedge ref_clk_i)
	begin
		prog_data_o <= prog[prog_addr_i];
		dmem_rdata_o <= data[dmem_addr_i];
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (clr_i)
		begin
			for (int i = 0; i < 2048; i++)
				prog[i] <= 16'h0000;
			for (int i = 0; i < 256; i++)
				data[i] <= 8'h00;
			alias_writes_o <= 8'h00;
		end
		else if (ld_i)
		begin
			if (ld_prog_i)
				prog[ld_addr_i] <= ld_val_i;
			else
				data[ld_addr_i[7:0]] <= ld_val_i[7:0];
		end
		else if (dmem_we_i)
		begin
			data[dmem_addr_i] <= dmem_wdata_i;
			// Core registers must never reach the array
			if (dmem_addr_i >= 8'h06 && dmem_addr_i <= 8'h08)
				alias_writes_o <= alias_writes_o + 8'h01;
		end
	end
endmodule

`default_nettype wire

// ### miet_phase.sv
/*
 Four-phase counter that frames each instruction cycle.
 Assumes a synchronous active-high reset on the core clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "miet_cfg.svh"

module miet_phase (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Phase
	output logic [`MIET_PHASE_W-1:0] phase_o,
	output logic last_o
);
	always_ff @(posedge ref_clk_i)
	begin
		if (rst_i)
			phase_o <= '0;
		else
			phase_o <= phase_o + 2'h1;
	end

	assign last_o = (phase_o == `MIET_PHASE_LAST);

	a_phase_wrap: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		last_o |=> (phase_o == 2'h0) ##3 last_o)
		else $error("phase counter did not wrap after four clocks");

	a_phase_start: assert property (
		@(posedge ref_clk_i) disable iff (rst_i)
		$fell(rst_i) |-> (phase_o == 2'h0))
		else $error("phase not zero after reset release");

endmodule
`default_nettype wire

// ### miet_pkg.sv
/*
 Types of the instruction sequencing core: major opcodes, minor
 function codes and the sequencer states.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package miet_pkg;

	typedef enum logic [3:0] {
		OP_MISC, OP_LOAD_MEM, OP_STORE_MEM, OP_LOAD_IMM,
		OP_ALU_ACC, OP_ALU_MEM, OP_ALU_IMM, OP_BIT,
		OP_SKIP_BIT, OP_SKIP, OP_BRANCH, OP_CALL, OP_EXIT_IMM
	} miet_op_type;

	typedef enum logic [3:0] {
		FN_ADD, FN_ADC, FN_SUB, FN_SBC, FN_AND, FN_OR, FN_XOR,
		FN_INVERT, FN_INC, FN_DEC, FN_RIGHT_ROTATE, FN_LEFT_ROTATE,
		FN_RIGHT_ROTATE_VIA_CARRY, FN_LEFT_ROTATE_VIA_CARRY,
		FN_SWAP, FN_CLEAR
	} miet_fn_type;

	typedef enum logic [3:0] {
		MS_NOP, MS_SUBROUTINE_EXIT, MS_INTERRUPT_EXIT, MS_HALT,
		MS_WDT_CLEAR, MS_TABLE_READ
	} miet_misc_type;

	typedef enum logic [3:0] {
		SK_ZERO, SK_ZERO_ACC, SK_INC, SK_DEC, SK_INC_ACC, SK_DEC_ACC
	} miet_skip_type;

	typedef enum logic [1:0] {
		ST_RUN, ST_DEAD, ST_TABLE, ST_HALT
	} miet_state_type;

endpackage
